// ===== dv/cap_object_encoder_tb_top.sv
`timescale 1ns/1ns
module cap_object_encoder_tb_top;
    logic        MCLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic        START = 1'b0, CHR_EN = 1'b0, CLK_STOP_ANY = 1'b0, PREF_HIGH = 1'b0;
    logic        PREF_LOW = 1'b0, VCLASS_A = 1'b0, VCLASS_B = 1'b0, VCLASS_C = 1'b0;
    logic        PWR_EN = 1'b0, MINF_CLR = 1'b0, MINF_WR = 1'b0, MEM_EN = 1'b0;
    logic        MAX_SIZE_EN = 1'b0, FD_EN = 1'b0, DER_ONLY = 1'b0, RSV_EN = 1'b0;
    logic [7:0]  PWR_VCLASS = 8'h00, PWR_MA = 8'h00, PWR_REF_FREQ = 8'h00, MINF_WDATA = 8'h00;
    logic [15:0] MEM_AVAIL = 16'h0000, MAX_SIZE = 16'h0000, RSV_SIZE = 16'h0000;
    logic        TX_READY, TX_VALID, TX_LAST, BUSY, DONE;
    logic [7:0]  TX_DATA;
    logic [2:0]  MINF_COUNT;
    logic        stall = 1'b0;
    logic        ma_use = 1'b0;
    int          mismatches = 0;
    int          checks = 0;

    always #10 MCLK = ~MCLK;

    cap_object_encoder dut_u (
        .MCLK(MCLK), .SYS_RST(SYS_RST), .START(START), .CHR_EN(CHR_EN),
        .CLK_STOP_ANY(CLK_STOP_ANY), .PREF_HIGH(PREF_HIGH), .PREF_LOW(PREF_LOW),
        .VCLASS_A(VCLASS_A), .VCLASS_B(VCLASS_B), .VCLASS_C(VCLASS_C), .PWR_EN(PWR_EN),
        .PWR_VCLASS(PWR_VCLASS), .PWR_MA(PWR_MA), .PWR_REF_FREQ(PWR_REF_FREQ),
        .MINF_CLR(MINF_CLR), .MINF_WR(MINF_WR), .MINF_WDATA(MINF_WDATA), .MEM_EN(MEM_EN),
        .MEM_AVAIL(MEM_AVAIL), .MAX_SIZE_EN(MAX_SIZE_EN), .MAX_SIZE(MAX_SIZE),
        .FD_EN(FD_EN), .DER_ONLY(DER_ONLY), .RSV_EN(RSV_EN), .RSV_SIZE(RSV_SIZE),
        .TX_READY(TX_READY), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_LAST(TX_LAST),
        .BUSY(BUSY), .DONE(DONE), .MINF_COUNT(MINF_COUNT)
    );

    tx_sink sink_u (
        .MCLK(MCLK), .stall(stall), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
        .TX_LAST(TX_LAST), .TX_READY(TX_READY)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        if (mismatches == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic minf_write(input logic [7:0] d);
        @(posedge MCLK);
        #1 MINF_WR = 1'b1;
        MINF_WDATA = d;
        @(posedge MCLK);
        #1 MINF_WR = 1'b0;
    endtask : minf_write

    // walk the captured container as a terminal would
    task automatic parse_frame(input int base, input int n);
        int         p;
        logic [7:0] t;
        logic [7:0] l;
        logic [7:0] c;
        p = base + 2;
        while (p < base + n)
        begin
            t = sink_u.seen[p % 64];
            l = sink_u.seen[(p + 1) % 64];
            if (t[7:6] != 2'b11)
                check("olen", l, (t == cap_pkg::TAG_PWR) ? cap_pkg::LEN_PWR :
                      (t == cap_pkg::TAG_MEM) ? cap_pkg::LEN_MEM :
                      (t == cap_pkg::TAG_RSV) ? cap_pkg::LEN_RSV : 8'h01);
            if (t == cap_pkg::TAG_PWR)
            begin
                c = sink_u.seen[(p + 3) % 64];
                ma_use = c != 8'h00 && c != 8'hff && c <= 8'h3c;
            end
            p = p + 2 + int'(l);
        end
        check("overrun", p, base + n);
    endtask : parse_frame

    // one container request, then compare the captured bytes
    task automatic run_frame(input logic [7:0] exp[$], input logic stall_i);
        int base;
        int lasts;
        int i;
        stall = stall_i;
        base = sink_u.count;
        lasts = sink_u.lasts;
        i = 0;
        @(posedge MCLK);
        #1 START = 1'b1;
        @(posedge MCLK);
        #1 START = 1'b0;
        while (DONE !== 1'b1 && i < 300)
        begin
            @(posedge MCLK);
            #1 i++;
        end
        check("done", DONE, 1'b1);
        check("busy", BUSY, 1'b0);
        check("count", sink_u.count - base, exp.size());
        foreach (exp[k])
            check("byte", sink_u.seen[(base + k) % 64], exp[k]);
        check("last", sink_u.last_seen, 1'b1);
        check("lasts", sink_u.lasts - lasts, 1);
        parse_frame(base, sink_u.count - base);
    endtask : run_frame

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #100000 mismatches++;
        final_report();
    end

    initial
    begin
        repeat (16) @(posedge MCLK);
        #1 SYS_RST = 1'b0;
        check("valid", TX_VALID, 1'b0);
        check("mcount", MINF_COUNT, 3'h0);
        run_frame('{8'ha5, 8'h00}, 1'b0);
        CHR_EN = 1'b1;
        CLK_STOP_ANY = 1'b1;
        PREF_HIGH = 1'b1;
        PREF_LOW = 1'b1;
        VCLASS_A = 1'b1;
        VCLASS_C = 1'b1;
        run_frame('{8'ha5, 8'h03, 8'h80, 8'h01, 8'h51}, 1'b0);
        CLK_STOP_ANY = 1'b0;
        PREF_LOW = 1'b0;
        VCLASS_A = 1'b0;
        VCLASS_C = 1'b0;
        VCLASS_B = 1'b1;
        PWR_EN = 1'b1;
        PWR_VCLASS = 8'hff;
        PWR_MA = 8'hff;
        PWR_REF_FREQ = 8'h05;
        minf_write(8'h20);
        minf_write(8'h05);
        minf_write(8'h30);
        check("mcount", MINF_COUNT, 3'h3);
        MEM_EN = 1'b1;
        MEM_AVAIL = 16'h1234;
        MAX_SIZE_EN = 1'b1;
        MAX_SIZE = 16'h0100;
        FD_EN = 1'b1;
        DER_ONLY = 1'b1;
        RSV_EN = 1'b1;
        run_frame('{8'ha5, 8'h1c, 8'h80, 8'h01, 8'h24, 8'h81, 8'h03, 8'h07, 8'h3f, 8'hff,
                    8'h82, 8'h01, 8'h20, 8'h82, 8'h01, 8'hff, 8'h82, 8'h01, 8'h30,
                    8'h83, 8'h02, 8'h01, 8'h00, 8'h84, 8'h01, 8'h01, 8'h85, 8'h02, 8'h00,
                    8'h00}, 1'b1);
        check("ma_use", ma_use, 1'b0);
        minf_write(8'h40);
        minf_write(8'h50);
        check("mcount", MINF_COUNT, 3'h4);
        @(posedge MCLK);
        #1 MINF_CLR = 1'b1;
        @(posedge MCLK);
        #1 MINF_CLR = 1'b0;
        check("mcount", MINF_COUNT, 3'h0);
        CLK_STOP_ANY = 1'b1;
        PREF_HIGH = 1'b0;
        PREF_LOW = 1'b1;
        VCLASS_B = 1'b0;
        PWR_EN = 1'b0;
        MAX_SIZE_EN = 1'b0;
        DER_ONLY = 1'b0;
        RSV_EN = 1'b0;
        run_frame('{8'ha5, 8'h0a, 8'h80, 8'h01, 8'h09, 8'h83, 8'h02, 8'h12, 8'h34,
                    8'h84, 8'h01, 8'h00}, 1'b0);
        final_report();
    end
endmodule : cap_object_encoder_tb_top

// ===== dv/tx_sink.sv
`timescale 1ns/1ns
module tx_sink (
    input  wire logic       MCLK,
    input  wire logic       stall,
    input  wire logic [7:0] TX_DATA,
    input  wire logic       TX_VALID,
    input  wire logic       TX_LAST,
    output logic            TX_READY
);
    logic [7:0] seen [0:63];
    int         count;
    logic       last_seen;
    int         lasts;
    initial
    begin
        TX_READY  = 1'b0;
        count     = 0;
        lasts     = 0;
        last_seen = 1'b0;
    end
    // capture container bytes in arrival order
    always @(posedge MCLK)
    begin
        if (TX_VALID === 1'b1 && TX_READY === 1'b1)
        begin
            seen[count % 64] = TX_DATA;
            count = count + 1;
            last_seen = TX_LAST;
            if (TX_LAST === 1'b1)
            begin
                lasts = lasts + 1;
            end
        end
        TX_READY <= #1 stall ? ~TX_READY : 1'b1;
    end
endmodule : tx_sink

// ===== rtl/cap_object_encoder.sv
// Functional notes
// R1: all objects go inside an A5 container whose length byte sizes its value; a minimum frequency write or clear in the START cycle is not counted.
// R2: private entries after defined ones are skipped by the parser on the far side.
// R3: characteristics object is tag 80, length 01, one characteristics byte.
// R4: b1 allows stop at any level; b3/b4 preference; both set is reserved.
// R5: with b1 clear the terminal stops only at the flagged level, never if none.
// R6: bits b5, b6, b7 flag voltage classes A, B, C as supported.
// R7: reserved bits b8 and b2 of the characteristics byte are driven zero.
// R8: power object is tag 81, length 03, first byte voltage class, unused bits zero.
// R9: second power byte keeps b8,b7 zero and carries current in mA in b6..b1.
// R10: terminal drops current codes 00 and FF and ignores values above 3C.
// R11: reference frequency in 0.1 MHz steps 0A..FE; FF means none given.
// R12: current is a 1 ms average at reference or at maximum supported clock.
// R13: terminal rescales current to the class in use before accepting.
// R14: minimum frequency object is tag 82, length 01, 0A upward, FF means none.
// R15: several minimum frequency objects keep their order in the container.
// R16: available memory object is tag 83, at least two bytes, MSB first.
// R17: available memory for TLV files never lets a new object pass maximum size.
// R18: file details object is tag 84, one byte, b1 means DER only.
// R19: reserved size object is tag 85, at least two bytes, MSB first.
// R20: with no memory reserved the reserved size object still goes out as zero.
// R21: terminal flags lengths that disagree or overrun the container.
`timescale 1ns/1ns
module cap_object_encoder (
    input  wire logic        MCLK,
    input  wire logic        SYS_RST,
    input  wire logic        START,
    input  wire logic        CHR_EN,
    input  wire logic        CLK_STOP_ANY,
    input  wire logic        PREF_HIGH,
    input  wire logic        PREF_LOW,
    input  wire logic        VCLASS_A,
    input  wire logic        VCLASS_B,
    input  wire logic        VCLASS_C,
    input  wire logic        PWR_EN,
    input  wire logic [7:0]  PWR_VCLASS,
    input  wire logic [7:0]  PWR_MA,
    input  wire logic [7:0]  PWR_REF_FREQ,
    input  wire logic        MINF_CLR,
    input  wire logic        MINF_WR,
    input  wire logic [7:0]  MINF_WDATA,
    input  wire logic        MEM_EN,
    input  wire logic [15:0] MEM_AVAIL,
    input  wire logic        MAX_SIZE_EN,
    input  wire logic [15:0] MAX_SIZE,
    input  wire logic        FD_EN,
    input  wire logic        DER_ONLY,
    input  wire logic        RSV_EN,
    input  wire logic [15:0] RSV_SIZE,
    input  wire logic        TX_READY,
    output logic      [7:0]  TX_DATA,
    output logic             TX_VALID,
    output logic             TX_LAST,
    output logic             BUSY,
    output logic             DONE,
    output logic      [2:0]  MINF_COUNT
);

    typedef struct packed {
        cap_pkg::phase_t phase;
        logic [2:0]      obj;
        logic [1:0]      minf_idx;
        logic [1:0]      vidx;
        logic [2:0]      minf_count;
        logic [5:0]      en;
        logic [7:0]      clen;
        logic [7:0]      chr;
        logic [7:0]      pwr_vclass;
        logic [7:0]      pwr_ma;
        logic [7:0]      pwr_ref;
        logic [15:0]     mem_avail;
        logic [7:0]      fd;
        logic [15:0]     rsv_size;
        logic [7:0]      tx_data;
        logic            tx_valid;
        logic            tx_last;
        logic            busy;
        logic            done;
        cap_pkg::phase_t out_phase;
        logic [2:0]      out_obj;
        logic [5:0]      byte_no;
    } state_t;

    state_t     s;
    state_t     next_s;
    logic [7:0] chr_byte;
    logic [7:0] minf_rdata;
    logic [7:0] minf_wdata;
    logic       minf_we;
    logic       start_ok;

    ////////////////////////////////////////////////////////////////////////////////

    function automatic logic [7:0] obj_len(input logic [2:0] obj);
        case (obj)
            cap_pkg::OBJ_CHR:  return cap_pkg::LEN_CHR;  // R3
            cap_pkg::OBJ_PWR:  return cap_pkg::LEN_PWR;  // R8
            cap_pkg::OBJ_MINF: return cap_pkg::LEN_MINF; // R14
            cap_pkg::OBJ_MEM:  return cap_pkg::LEN_MEM;  // R16
            cap_pkg::OBJ_FD:   return cap_pkg::LEN_FD;   // R18
            cap_pkg::OBJ_RSV:  return cap_pkg::LEN_RSV;  // R19
            default:           return 8'h00;
        endcase
    endfunction : obj_len

    function automatic logic [7:0] obj_tag(input logic [2:0] obj);
        case (obj)
            cap_pkg::OBJ_CHR:  return cap_pkg::TAG_CHR;  // R3
            cap_pkg::OBJ_PWR:  return cap_pkg::TAG_PWR;  // R8
            cap_pkg::OBJ_MINF: return cap_pkg::TAG_MINF; // R14
            cap_pkg::OBJ_MEM:  return cap_pkg::TAG_MEM;  // R16
            cap_pkg::OBJ_FD:   return cap_pkg::TAG_FD;   // R18
            cap_pkg::OBJ_RSV:  return cap_pkg::TAG_RSV;  // R19
            default:           return 8'h00;
        endcase
    endfunction : obj_tag

    // first enabled object at or after a given position
    function automatic logic [2:0] first_from(input logic [2:0] from, input logic [5:0] en);
        logic [2:0] r;
        r = cap_pkg::OBJ_END;
        for (int i = cap_pkg::NUM_OBJ - 1; i >= 0; i--)
        begin
            if (3'(i) >= from && en[i])
            begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : first_from

    function automatic logic [7:0] cont_len(input logic [5:0] en, input logic [2:0] cnt);
        logic [7:0] sum;
        sum = 8'h00;
        for (int i = 0; i < cap_pkg::NUM_OBJ; i++)
        begin
            if (en[i] && 3'(i) != cap_pkg::OBJ_MINF)
            begin
                sum = 8'(sum + cap_pkg::TL_BYTES + obj_len(3'(i)));
            end
        end
        if (en[cap_pkg::OBJ_MINF])
        begin
            sum = 8'(sum + 8'(cnt) * 8'(cap_pkg::TL_BYTES + cap_pkg::LEN_MINF));
        end
        return sum;
    endfunction : cont_len

    ////////////////////////////////////////////////////////////////////////////////

    chr_byte_builder u_chr (
        .clk_stop_any (CLK_STOP_ANY),
        .pref_high    (PREF_HIGH),
        .pref_low     (PREF_LOW),
        .vclass_a     (VCLASS_A),
        .vclass_b     (VCLASS_B),
        .vclass_c     (VCLASS_C),
        .chr          (chr_byte)
    );

    // list is only edited while idle; busy rises after START, so an edit in the START cycle is missed by the container length
    assign minf_we    = MINF_WR && !MINF_CLR && !s.busy && s.minf_count < cap_pkg::MINF_FULL;
    assign minf_wdata = (MINF_WDATA < cap_pkg::FREQ_MIN) ? cap_pkg::FREQ_NONE : MINF_WDATA; // R14
    assign start_ok   = START && s.phase == cap_pkg::PH_IDLE && !s.tx_valid;

    minf_store u_minf (
        .clk   (MCLK),
        .rst   (SYS_RST),
        .wr_en (minf_we),
        .waddr (s.minf_count[1:0]),
        .wdata (minf_wdata),
        .raddr (s.minf_idx), // R15
        .rdata (minf_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        logic [7:0] val;
        logic [2:0] nobj;
        logic [5:0] en;
        val    = 8'h00;
        nobj   = cap_pkg::OBJ_END;
        en     = 6'h00;
        next_s = s;
        next_s.done = 1'b0;

        if (s.tx_valid && TX_READY)
        begin
            next_s.tx_valid = 1'b0;
            next_s.tx_last  = 1'b0;
            next_s.byte_no  = s.byte_no + 6'h01;
            next_s.done     = s.tx_last;
        end

        if (MINF_CLR && !s.busy)
        begin
            next_s.minf_count = 3'h0;
        end
        else if (minf_we)
        begin
            next_s.minf_count = s.minf_count + 3'h1;
        end

        if (start_ok)
        begin
            en = {RSV_EN, FD_EN, MEM_EN, s.minf_count != 3'h0, PWR_EN, CHR_EN};
            next_s.en         = en;
            next_s.obj        = first_from(cap_pkg::OBJ_CHR, en);
            next_s.minf_idx   = 2'h0;
            next_s.clen       = cont_len(en, s.minf_count); // R1
            next_s.chr        = chr_byte;
            next_s.pwr_vclass = PWR_VCLASS & cap_pkg::PWR_VCLASS_MASK; // R8
            next_s.pwr_ma     = PWR_MA & cap_pkg::PWR_MA_MASK; // R9
            // codes below 0A are not valid frequencies: report none instead
            next_s.pwr_ref    = (PWR_REF_FREQ < cap_pkg::FREQ_MIN) ?
                                cap_pkg::FREQ_NONE : PWR_REF_FREQ; // R11 R12
            next_s.mem_avail  = (MAX_SIZE_EN && MEM_AVAIL > MAX_SIZE) ?
                                MAX_SIZE : MEM_AVAIL; // R17
            next_s.fd         = DER_ONLY ? cap_pkg::FD_DER_ONLY : cap_pkg::FD_NONE; // R18
            next_s.rsv_size   = RSV_SIZE; // R20
            next_s.byte_no    = 6'h00;
            next_s.phase      = cap_pkg::PH_CTAG;
        end
        else if ((!s.tx_valid || TX_READY) && s.phase != cap_pkg::PH_IDLE)
        begin
            next_s.tx_valid  = 1'b1;
            next_s.out_phase = s.phase;
            next_s.out_obj   = s.obj;
            case (s.phase)
                cap_pkg::PH_CTAG:
                begin
                    next_s.tx_data = cap_pkg::TAG_CONTAINER; // R1
                    next_s.phase   = cap_pkg::PH_CLEN;
                end
                cap_pkg::PH_CLEN:
                begin
                    next_s.tx_data = s.clen; // R1
                    if (s.obj == cap_pkg::OBJ_END)
                    begin
                        next_s.tx_last = 1'b1;
                        next_s.phase   = cap_pkg::PH_IDLE;
                    end
                    else
                    begin
                        next_s.phase = cap_pkg::PH_OTAG;
                    end
                end
                cap_pkg::PH_OTAG:
                begin
                    next_s.tx_data = obj_tag(s.obj);
                    next_s.phase   = cap_pkg::PH_OLEN;
                end
                cap_pkg::PH_OLEN:
                begin
                    next_s.tx_data = obj_len(s.obj);
                    next_s.vidx    = 2'h0;
                    next_s.phase   = cap_pkg::PH_OVAL;
                end
                cap_pkg::PH_OVAL:
                begin
                    case (s.obj)
                        cap_pkg::OBJ_CHR:  val = s.chr; // R3
                        cap_pkg::OBJ_PWR:  val = (s.vidx == 2'h0) ? s.pwr_vclass :
                                                 (s.vidx == 2'h1) ? s.pwr_ma : s.pwr_ref;
                        cap_pkg::OBJ_MINF: val = minf_rdata; // R15
                        cap_pkg::OBJ_MEM:  val = (s.vidx == 2'h0) ? s.mem_avail[15:8] :
                                                 s.mem_avail[7:0]; // R16
                        cap_pkg::OBJ_FD:   val = s.fd;
                        cap_pkg::OBJ_RSV:  val = (s.vidx == 2'h0) ? s.rsv_size[15:8] :
                                                 s.rsv_size[7:0]; // R19
                        default:           val = 8'h00;
                    endcase
                    next_s.tx_data = val;
                    if (8'(s.vidx) + 8'h01 == obj_len(s.obj))
                    begin
                        if (s.obj == cap_pkg::OBJ_MINF &&
                            3'(s.minf_idx) + 3'h1 < s.minf_count) // R15
                        begin
                            next_s.minf_idx = s.minf_idx + 2'h1;
                            next_s.phase    = cap_pkg::PH_OTAG;
                        end
                        else
                        begin
                            nobj       = first_from(3'(s.obj + 3'h1), s.en);
                            next_s.obj = nobj;
                            if (nobj == cap_pkg::OBJ_END)
                            begin
                                next_s.tx_last = 1'b1;
                                next_s.phase   = cap_pkg::PH_IDLE;
                            end
                            else
                            begin
                                next_s.phase = cap_pkg::PH_OTAG;
                            end
                        end
                    end
                    else
                    begin
                        next_s.vidx = s.vidx + 2'h1;
                    end
                end
                default:
                begin
                    next_s.phase = cap_pkg::PH_IDLE;
                end
            endcase
        end

        next_s.busy = next_s.phase != cap_pkg::PH_IDLE || next_s.tx_valid;
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign TX_DATA    = s.tx_data;
    assign TX_VALID   = s.tx_valid;
    assign TX_LAST    = s.tx_last;
    assign BUSY       = s.busy;
    assign DONE       = s.done;
    assign MINF_COUNT = s.minf_count;

    ////////////////////////////////////////////////////////////////////////////////

    property p_cont_tag;
        @(posedge MCLK) disable iff (SYS_RST)
        start_ok |=> ##1 (s.tx_valid && s.tx_data == cap_pkg::TAG_CONTAINER && s.byte_no == 6'h00);
    endproperty
    a_cont_tag: assert property (p_cont_tag) else $error("container tag missing"); // R1

    property p_cont_size;
        @(posedge MCLK) disable iff (SYS_RST)
        (s.tx_valid && s.tx_last) |-> (8'(s.byte_no) == 8'(s.clen + 8'h01));
    endproperty
    a_cont_size: assert property (p_cont_size) else $error("container length mismatch"); // R1

    property p_chr_obj;
        @(posedge MCLK) disable iff (SYS_RST)
        (s.tx_valid && s.out_obj == cap_pkg::OBJ_CHR && s.out_phase == cap_pkg::PH_OTAG)
            |-> s.tx_data == 8'h80 ##1 (!s.tx_valid || s.out_phase != cap_pkg::PH_OLEN
                                        || s.tx_data == 8'h01);
    endproperty
    a_chr_obj: assert property (p_chr_obj) else $error("characteristics header wrong"); // R3

    property p_pref;
        @(posedge MCLK) disable iff (SYS_RST)
        start_ok |=> !(s.chr[cap_pkg::CHR_HIGH_BIT] && s.chr[cap_pkg::CHR_LOW_BIT]);
    endproperty
    a_pref: assert property (p_pref) else $error("reserved level preference emitted"); // R4

    property p_vclass;
        @(posedge MCLK) disable iff (SYS_RST)
        start_ok |=> (s.chr[6:4] == {$past(VCLASS_C), $past(VCLASS_B), $past(VCLASS_A)});
    endproperty
    a_vclass: assert property (p_vclass) else $error("voltage class bits wrong"); // R6

    property p_chr_rsv;
        @(posedge MCLK) disable iff (SYS_RST)
        (s.tx_valid && s.out_obj == cap_pkg::OBJ_CHR && s.out_phase == cap_pkg::PH_OVAL)
            |-> (s.tx_data & 8'h82) == 8'h00;
    endproperty
    a_chr_rsv: assert property (p_chr_rsv) else $error("reserved chr bits set"); // R7

    property p_pwr_ma;
        @(posedge MCLK) disable iff (SYS_RST)
        start_ok |=> s.pwr_ma == ($past(PWR_MA) & 8'h3f);
    endproperty
    a_pwr_ma: assert property (p_pwr_ma) else $error("current byte not masked"); // R9

    property p_ref;
        @(posedge MCLK) disable iff (SYS_RST)
        start_ok |=> (s.pwr_ref == 8'hff || s.pwr_ref >= 8'h0a);
    endproperty
    a_ref: assert property (p_ref) else $error("reference frequency out of range"); // R11

    property p_minf;
        @(posedge MCLK) disable iff (SYS_RST)
        (s.tx_valid && s.out_obj == cap_pkg::OBJ_MINF && s.out_phase == cap_pkg::PH_OVAL)
            |-> s.tx_data >= 8'h0a;
    endproperty
    a_minf: assert property (p_minf) else $error("minimum frequency below 0a"); // R14

    property p_two_byte;
        @(posedge MCLK) disable iff (SYS_RST)
        (s.tx_valid && s.out_phase == cap_pkg::PH_OLEN &&
         (s.out_obj == cap_pkg::OBJ_MEM || s.out_obj == cap_pkg::OBJ_RSV))
            |-> s.tx_data == 8'h02;
    endproperty
    a_two_byte: assert property (p_two_byte) else $error("size object length wrong"); // R16

    property p_mem_cap;
        @(posedge MCLK) disable iff (SYS_RST)
        (start_ok && MAX_SIZE_EN) |=> s.mem_avail <= $past(MAX_SIZE);
    endproperty
    a_mem_cap: assert property (p_mem_cap) else $error("available memory above maximum"); // R17

    property p_hold;
        @(posedge MCLK) disable iff (SYS_RST)
        (s.tx_valid && !TX_READY) |=> (s.tx_valid && $stable(s.tx_data) && $stable(s.tx_last));
    endproperty
    a_hold: assert property (p_hold) else $error("byte changed while stalled");

endmodule : cap_object_encoder

// ===== rtl/cap_pkg.sv
package cap_pkg;

    // container and object tags
    localparam logic [7:0] TAG_CONTAINER = 8'ha5;
    localparam logic [7:0] TAG_CHR       = 8'h80;
    localparam logic [7:0] TAG_PWR       = 8'h81;
    localparam logic [7:0] TAG_MINF      = 8'h82;
    localparam logic [7:0] TAG_MEM       = 8'h83;
    localparam logic [7:0] TAG_FD        = 8'h84;
    localparam logic [7:0] TAG_RSV       = 8'h85;

    // value field lengths, and the tag plus length byte count
    localparam logic [7:0] LEN_CHR  = 8'h01;
    localparam logic [7:0] LEN_PWR  = 8'h03;
    localparam logic [7:0] LEN_MINF = 8'h01;
    localparam logic [7:0] LEN_MEM  = 8'h02;
    localparam logic [7:0] LEN_FD   = 8'h01;
    localparam logic [7:0] LEN_RSV  = 8'h02;
    localparam logic [7:0] TL_BYTES = 8'h02;

    // characteristics byte field positions (bit 0 is b1)
    localparam int         CHR_STOP_BIT = 0;
    localparam int         CHR_HIGH_BIT = 2;
    localparam int         CHR_LOW_BIT  = 3;
    localparam int         CHR_VA_BIT   = 4;
    localparam int         CHR_VB_BIT   = 5;
    localparam int         CHR_VC_BIT   = 6;
    localparam logic [7:0] CHR_RSV_MASK = 8'h82;

    // value codings
    localparam logic [7:0] PWR_VCLASS_MASK = 8'h07;
    localparam logic [7:0] PWR_MA_MASK     = 8'h3f;
    localparam logic [7:0] FREQ_MIN        = 8'h0a;
    localparam logic [7:0] FREQ_NONE       = 8'hff;
    localparam logic [7:0] FD_DER_ONLY     = 8'h01;
    localparam logic [7:0] FD_NONE         = 8'h00;

    // object codes, in emission order
    localparam logic [2:0] OBJ_CHR  = 3'h0;
    localparam logic [2:0] OBJ_PWR  = 3'h1;
    localparam logic [2:0] OBJ_MINF = 3'h2;
    localparam logic [2:0] OBJ_MEM  = 3'h3;
    localparam logic [2:0] OBJ_FD   = 3'h4;
    localparam logic [2:0] OBJ_RSV  = 3'h5;
    localparam logic [2:0] OBJ_END  = 3'h6;
    localparam int         NUM_OBJ  = 6;

    // minimum frequency list store
    localparam int         MINF_DEPTH     = 4;
    localparam int         MINF_AW        = 2;
    localparam logic [2:0] MINF_FULL      = 3'h4;
    localparam logic [7:0] MINF_RDATA_RST = 8'hff;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_CTAG,
        PH_CLEN,
        PH_OTAG,
        PH_OLEN,
        PH_OVAL
    } phase_t;

endpackage : cap_pkg

// ===== rtl/chr_byte_builder.sv
`timescale 1ns/1ns
module chr_byte_builder (
    input  wire logic       clk_stop_any,
    input  wire logic       pref_high,
    input  wire logic       pref_low,
    input  wire logic       vclass_a,
    input  wire logic       vclass_b,
    input  wire logic       vclass_c,
    output logic      [7:0] chr
);

    always_comb
    begin
        chr = 8'h00;
        chr[cap_pkg::CHR_STOP_BIT] = clk_stop_any;
        // both levels at once is a reserved code: fall back to all zero levels
        if (!(pref_high && pref_low)) // R4 R5
        begin
            chr[cap_pkg::CHR_HIGH_BIT] = pref_high;
            chr[cap_pkg::CHR_LOW_BIT]  = pref_low;
        end
        chr[cap_pkg::CHR_VA_BIT] = vclass_a; // R6
        chr[cap_pkg::CHR_VB_BIT] = vclass_b; // R6
        chr[cap_pkg::CHR_VC_BIT] = vclass_c; // R6
        chr = chr & ~cap_pkg::CHR_RSV_MASK; // R7
    end

endmodule : chr_byte_builder

// ===== rtl/minf_store.sv
`timescale 1ns/1ns
module minf_store (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         wr_en,
    input  wire logic [cap_pkg::MINF_AW-1:0]  waddr,
    input  wire logic [7:0]                   wdata,
    input  wire logic [cap_pkg::MINF_AW-1:0]  raddr,
    output logic      [7:0]                   rdata
);

    logic [7:0] mem [cap_pkg::MINF_DEPTH];

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[waddr] <= wdata;
        end
    end

    // registered read: data follows the address by one clock
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata <= cap_pkg::MINF_RDATA_RST;
        end
        else
        begin
            rdata <= mem[raddr];
        end
    end

endmodule : minf_store
